// >>> sdg_watchdog.v
// standalone watchdog: key decoder, protected registers, update flags, down-counter
//
// Functional notes
// R01: key CCCC starts the counter; no effect once hardware start enabled it.
// R02: key AAAA loads counter with reload value, restarting the count.
// R03: key 5555 removes write protection of prescale and reload registers.
// R04: key 4567 freezes the running counter.
// R05: key 89AB releases the freeze, counting resumes.
// R06: prescale writes ignored unless key field holds 5555.
// R07: prescale value unchanged while its update flag is set.
// R08: divider codes 0..5 give /4../128, others /256.
// R09: prescale read returns held value; valid only when its flag is zero.
// R10: 12-bit reload value at bits 11:0, resets to FFF.
// R11: reload value writable only while unlocked by the key.
// R12: reload value changes only while its update flag is zero.
// R13: reload read returns held value; valid only when its flag is zero.
// R14: status bit 1 set during reload transfer, cleared by hardware.
// R15: status bit 0 set during prescale transfer, cleared by hardware.
// R16: 16-bit key field resets to zero; only command words act.
// R17: reset request when the enabled counter reaches zero.
// R18: counting starts at FFF, one step per prescaled tick.
// R19: any key other than 5555 restores write protection.
// R20: reload command also restores write protection.
// R21: while frozen, counter holds and no reset is raised.
// R22: update flag rises with the accepted write, held until value usable.
`timescale 1ns/1ns
`include "sdg_consts.vh"
module sdg_watchdog
(
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // register port
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    // low-speed oscillator pin and hardware start strap
    input wire low_speed_osc,
    input wire hw_start_opt,
    // watchdog outputs
    output reg wdg_reset_req,
    output reg wdg_running,
    output reg [11:0] wdg_count
);

    // ****************************************
    // storage
    // ****************************************
    reg [15:0] key_reg;
    reg [2:0] presc_reg;
    reg [2:0] presc_act_reg;
    reg presc_busy_reg;
    reg [1:0] presc_upd_reg;
    reg [11:0] reload_reg;
    reg [11:0] reload_act_reg;
    reg reload_busy_reg;
    reg [1:0] reload_upd_reg;
    reg frozen_reg;
    reg hw_opt_seen_reg;
    reg hw_started_reg;
    reg restart_reg;
    reg strap_meta_reg;
    reg strap_sync_reg;
    reg [1:0] strap_wait_reg;

    wire osc_tick;
    wire div_tick;
    wire unlocked;
    wire key_wr;
    wire presc_wr;
    wire reload_wr;
    wire cmd_start;
    wire cmd_reload;
    wire cmd_freeze;
    wire cmd_thaw;

    // ****************************************
    // decoding
    // ****************************************
    assign unlocked = (key_reg == `SDG_KEY_UNLOCK); // R03
    assign key_wr = reg_wr_en && (reg_addr == `SDG_OFS_KEY);
    // protection and busy both gate the write; a refused write is simply dropped
    assign presc_wr = reg_wr_en && (reg_addr == `SDG_OFS_PRESC)
        && unlocked && !presc_busy_reg; // R06 R07
    assign reload_wr = reg_wr_en && (reg_addr == `SDG_OFS_RELOAD)
        && unlocked && !reload_busy_reg; // R11 R12
    assign cmd_start = key_wr && (reg_wdata[15:0] == `SDG_KEY_START);
    assign cmd_reload = key_wr && (reg_wdata[15:0] == `SDG_KEY_RELOAD);
    // freeze and thaw words, acted on by the counter process
    assign cmd_freeze = key_wr && (reg_wdata[15:0] == `SDG_KEY_FREEZE);
    assign cmd_thaw = key_wr && (reg_wdata[15:0] == `SDG_KEY_THAW);

    // ****************************************
    // low-speed clock tick and prescaler
    // ****************************************
    sdg_tick_sync u_sync
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .osc_in(low_speed_osc),
        .tick(osc_tick)
    );

    sdg_prescaler u_presc
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(wdg_running && !frozen_reg),
        .restart(restart_reg),
        .divider_code(presc_act_reg),
        .osc_tick(osc_tick),
        .div_tick(div_tick)
    );

    // ****************************************
    // key register
    // ****************************************
    // every key write lands here, so any non-unlock word relocks
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            key_reg <= `SDG_KEY_RST; // R16
        end
        else if (key_wr)
        begin
            key_reg <= reg_wdata[15:0]; // R19 R20
        end
    end

    // ****************************************
    // hardware start strap
    // ****************************************
    // the strap is a pin like any other, so it passes two flops first;
    // the wait count lets both stages fill before the value is trusted
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
            strap_wait_reg <= 2'h0;
        end
        else
        begin
            strap_meta_reg <= hw_start_opt;
            strap_sync_reg <= strap_meta_reg;
            if (strap_wait_reg != `SDG_STRAP_WAIT)
            begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    // strap taken once after the synchroniser settles; later pin changes are ignored
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hw_opt_seen_reg <= 1'b0;
            hw_started_reg <= 1'b0;
        end
        else if (!hw_opt_seen_reg && (strap_wait_reg == `SDG_STRAP_WAIT))
        begin
            hw_opt_seen_reg <= 1'b1;
            hw_started_reg <= strap_sync_reg; // R01
        end
    end

    // ****************************************
    // prescale register and its transfer
    // ****************************************
    // active copy is what the counter uses; it changes only when the flag drops
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            presc_reg <= `SDG_PRESC_RST;
            presc_act_reg <= `SDG_PRESC_RST;
            presc_busy_reg <= 1'b0;
            presc_upd_reg <= 2'h0;
        end
        else if (presc_wr)
        begin
            presc_reg <= reg_wdata[`SDG_PRESC_MSB:0];
            presc_busy_reg <= 1'b1; // R22 R15
            presc_upd_reg <= 2'h0;
        end
        else if (presc_busy_reg && osc_tick)
        begin
            if (presc_upd_reg == (`SDG_UPD_TICKS - 2'h1))
            begin
                presc_busy_reg <= 1'b0; // R15
                presc_act_reg <= presc_reg;
            end
            presc_upd_reg <= presc_upd_reg + 2'h1;
        end
    end

    // ****************************************
    // reload register and its transfer
    // ****************************************
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reload_reg <= `SDG_RELOAD_RST; // R10
            reload_act_reg <= `SDG_RELOAD_RST;
            reload_busy_reg <= 1'b0;
            reload_upd_reg <= 2'h0;
        end
        else if (reload_wr)
        begin
            reload_reg <= reg_wdata[`SDG_RELOAD_MSB:0];
            reload_busy_reg <= 1'b1; // R22 R14
            reload_upd_reg <= 2'h0;
        end
        else if (reload_busy_reg && osc_tick)
        begin
            if (reload_upd_reg == (`SDG_UPD_TICKS - 2'h1))
            begin
                reload_busy_reg <= 1'b0; // R14
                reload_act_reg <= reload_reg;
            end
            reload_upd_reg <= reload_upd_reg + 2'h1;
        end
    end

    // ****************************************
    // run, freeze and down-counter
    // ****************************************
    // a reload during a pending transfer uses the last transferred value
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wdg_running <= 1'b0;
            frozen_reg <= 1'b0;
            wdg_count <= `SDG_CNT_START;
            wdg_reset_req <= 1'b0;
            restart_reg <= 1'b0;
        end
        else
        begin
            restart_reg <= 1'b0;
            if (hw_started_reg)
            begin
                wdg_running <= 1'b1;
            end
            else if (cmd_start)
            begin
                wdg_running <= 1'b1; // R01 R18
            end
            if (cmd_freeze && wdg_running)
            begin
                frozen_reg <= 1'b1; // R04
            end
            else if (cmd_thaw)
            begin
                frozen_reg <= 1'b0; // R05
            end
            if (cmd_reload)
            begin
                wdg_count <= reload_act_reg; // R02
                restart_reg <= 1'b1;
            end
            else if (div_tick && wdg_running && !frozen_reg && (wdg_count != 12'h000))
            begin
                wdg_count <= wdg_count - 12'h001; // R18 R21
            end
            // request stays until system reset takes the block down
            if (wdg_running && !frozen_reg && (wdg_count == 12'h000) && !cmd_reload)
            begin
                wdg_reset_req <= 1'b1; // R17 R21
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // key is write-only and reads as its reset value, zero
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else if (reg_rd_en)
        begin
            case (reg_addr)
                `SDG_OFS_PRESC: reg_rdata <= {29'h0000_0000, presc_reg}; // R09
                `SDG_OFS_RELOAD: reg_rdata <= {20'h0_0000, reload_reg}; // R13
                `SDG_OFS_STATUS: reg_rdata <= {30'h0000_0000, reload_busy_reg,
                    presc_busy_reg}; // R14 R15
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// >>> sdg_consts.vh
// constants for the standalone watchdog register block
`ifndef SDG_CONSTS_VH
`define SDG_CONSTS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SDG_OFS_KEY 4'h0
`define SDG_OFS_PRESC 4'h4
`define SDG_OFS_RELOAD 4'h8
`define SDG_OFS_STATUS 4'hC

// ****************************************
// field positions and widths
// ****************************************
`define SDG_KEY_MSB 15
`define SDG_PRESC_MSB 2
`define SDG_RELOAD_MSB 11
`define SDG_STS_PRESC_BIT 0
`define SDG_STS_RELOAD_BIT 1

// ****************************************
// command words of the key field
// ****************************************
`define SDG_KEY_START 16'hCCCC
`define SDG_KEY_RELOAD 16'hAAAA
`define SDG_KEY_UNLOCK 16'h5555
`define SDG_KEY_FREEZE 16'h4567
`define SDG_KEY_THAW 16'h89AB

// ****************************************
// reset values
// ****************************************
`define SDG_KEY_RST 16'h0000
`define SDG_PRESC_RST 3'h0
`define SDG_RELOAD_RST 12'hFFF
`define SDG_CNT_START 12'hFFF

// ****************************************
// timing counts
// ****************************************
// low-speed ticks a new setting needs to reach the slow domain
`define SDG_UPD_TICKS 2'h2
// clock edges after reset release before the synchronised strap is trusted
`define SDG_STRAP_WAIT 2'h2

`endif

// >>> sdg_tick_sync.v
// two-flop synchroniser and rising-edge detector for the low-speed oscillator
`timescale 1ns/1ns
module sdg_tick_sync
(
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // oscillator pin in, tick out
    input wire osc_in,
    output reg tick
);

    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    // only sync_reg looks at meta_reg; the edge is taken after the second stage
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            tick <= 1'b0;
        end
        else
        begin
            meta_reg <= osc_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            tick <= sync_reg & ~last_reg;
        end
    end

endmodule

// >>> sdg_prescaler.v
// prescaler dividing low-speed ticks by 4 to 256
`timescale 1ns/1ns
`include "sdg_consts.vh"
module sdg_prescaler
(
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // control
    input wire run,
    input wire restart,
    input wire [2:0] divider_code,
    input wire osc_tick,
    // output
    output reg div_tick
);

    reg [7:0] div_cnt_reg;

    // last count value for a given code; codes 6 and 7 both give /256
    function [7:0] sdg_div_last;
        input [2:0] code;
        begin
            case (code)
                3'h0: sdg_div_last = 8'h03;
                3'h1: sdg_div_last = 8'h07;
                3'h2: sdg_div_last = 8'h0F;
                3'h3: sdg_div_last = 8'h1F;
                3'h4: sdg_div_last = 8'h3F;
                3'h5: sdg_div_last = 8'h7F;
                default: sdg_div_last = 8'hFF;
            endcase
        end
    endfunction

    // restart keeps a reload from being followed by a short first step
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_cnt_reg <= 8'h00;
            div_tick <= 1'b0;
        end
        else
        begin
            div_tick <= 1'b0;
            if (restart || !run)
            begin
                div_cnt_reg <= 8'h00;
            end
            else if (osc_tick)
            begin
                if (div_cnt_reg >= sdg_div_last(divider_code)) // R08
                begin
                    div_cnt_reg <= 8'h00;
                    div_tick <= 1'b1;
                end
                else
                begin
                    div_cnt_reg <= div_cnt_reg + 8'h01;
                end
            end
        end
    end

endmodule

// >>> sdg_watchdog_assertions.sv
// port checker for the standalone watchdog
`timescale 1ns/1ns
`include "sdg_consts.vh"
module sdg_watchdog_assertions
(
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // register port
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    // oscillator and strap
    input wire low_speed_osc,
    input wire hw_start_opt,
    // watchdog outputs
    input wire wdg_reset_req,
    input wire wdg_running,
    input wire [11:0] wdg_count
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // key command write
    sequence s_key(k);
        reg_wr_en && reg_addr == `SDG_OFS_KEY && reg_wdata[15:0] == k;
    endsequence
    // count moved with no write in the two cycles before, so a reload cannot explain it
    sequence s_tick;
        !$past(reg_wr_en) && !$past(reg_wr_en, 2) && $changed(wdg_count);
    endsequence

    property p_req_cause;
        $rose(wdg_reset_req) |-> $past(wdg_count) == 12'h000;
    endproperty
    property p_req_hold;
        wdg_reset_req |=> wdg_reset_req;
    endproperty
    property p_step;
        s_tick |-> wdg_count == $past(wdg_count) - 12'h001;
    endproperty
    property p_run_only;
        s_tick |-> $past(wdg_running);
    endproperty
    property p_run_hold;
        wdg_running |=> wdg_running;
    endproperty
    property p_rd_hold;
        !reg_rd_en |=> $stable(reg_rdata);
    endproperty
    property p_key_zero;
        reg_rd_en && reg_addr == `SDG_OFS_KEY |=> reg_rdata == 32'h0;
    endproperty
    property p_sts_bits;
        reg_rd_en && reg_addr == `SDG_OFS_STATUS |=> reg_rdata[31:2] == 30'h0;
    endproperty
    // a few idle cycles after freezing, the count must sit still
    property p_frozen;
        s_key(`SDG_KEY_FREEZE) ##0 wdg_running ##1 !reg_wr_en [*6]
            |-> $stable(wdg_count) && !wdg_reset_req;
    endproperty

    a_req_cause: assert property (p_req_cause)
        else $error("request without zero count");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped");
    a_step: assert property (p_step)
        else $error("count moved by more than one");
    a_run_only: assert property (p_run_only)
        else $error("count moved while stopped");
    a_run_hold: assert property (p_run_hold)
        else $error("running dropped");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read");
    a_key_zero: assert property (p_key_zero)
        else $error("key read not zero");
    a_sts_bits: assert property (p_sts_bits)
        else $error("status upper bits set");
    a_frozen: assert property (p_frozen)
        else $error("frozen count moved");
endmodule

bind sdg_watchdog sdg_watchdog_assertions u_sdg_watchdog_assertions
(
    .mclk(mclk),
    .reset_n(reset_n),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .low_speed_osc(low_speed_osc),
    .hw_start_opt(hw_start_opt),
    .wdg_reset_req(wdg_reset_req),
    .wdg_running(wdg_running),
    .wdg_count(wdg_count)
);

// >>> tb_top.sv
// self-checking bench for the standalone watchdog
`timescale 1ns/1ns
`include "sdg_consts.vh"
module tb_top;
    // ********
    // stimulus and checks
    // ********
    localparam [3:0] o_key = `SDG_OFS_KEY;
    localparam [3:0] o_pre = `SDG_OFS_PRESC;
    localparam [3:0] o_rel = `SDG_OFS_RELOAD;
    localparam [3:0] o_sts = `SDG_OFS_STATUS;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg reg_wr_en = 1'b0;
    reg reg_rd_en = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg low_speed_osc = 1'b0;
    reg hw_start_opt = 1'b0;
    reg [3:0] osc_div = 4'h0;
    wire [31:0] reg_rdata;
    wire wdg_reset_req;
    wire wdg_running;
    wire [11:0] wdg_count;
    integer failures = 0;
    integer tests_run = 0;
    integer k;
    integer n;
    reg [31:0] rv;
    reg [11:0] c;

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // slow oscillator, 16 clocks a period so long divides stay affordable
    always @(posedge mclk)
    begin
        osc_div <= osc_div + 4'h1;
        low_speed_osc <= osc_div[3];
    end

    sdg_watchdog u_sdg_watchdog
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .low_speed_osc(low_speed_osc),
        .hw_start_opt(hw_start_opt),
        .wdg_reset_req(wdg_reset_req),
        .wdg_running(wdg_running),
        .wdg_count(wdg_count)
    );

    task chk(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    // strobes last one cycle, then an idle cycle so calls never collide
    task wr(input [3:0] a, input [31:0] d);
    begin
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        @(posedge mclk);
    end
    endtask

    task rd(input [3:0] a);
    begin
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        @(posedge mclk);
        rv = reg_rdata;
    end
    endtask

    // poll status until both transfers are over
    task settle;
    begin
        n = 0;
        rd(o_sts);
        while (rv !== 32'h0 && n < 100)
        begin
            rd(o_sts);
            n = n + 1;
        end
        chk(rv, 32'h0);
    end
    endtask

    // cycles between two count steps; first step is partial and skipped
    task measure;
    begin
        repeat (2)
        begin
            c = wdg_count;
            n = 0;
            while (wdg_count === c && n < 9000)
            begin
                @(negedge mclk);
                n = n + 1;
            end
        end
        @(posedge mclk);
    end
    endtask

    task t_reset;
    begin
        rd(o_pre);
        chk(rv, 32'h0);
        rd(o_rel);
        chk(rv, 32'hfff);
        rd(o_sts);
        chk(rv, 32'h0);
        rd(o_key);
        chk(rv, 32'h0);
        chk(wdg_count, 32'hfff);
        chk(wdg_running, 32'h0);
        $display("test reset done");
    end
    endtask

    task t_protect;
    begin
        wr(o_pre, 32'h3);
        wr(o_rel, 32'h123);
        rd(o_pre);
        chk(rv, 32'h0);
        rd(o_rel);
        chk(rv, 32'hfff);
        wr(o_key, 32'h5555);
        wr(o_pre, 32'h3);
        wr(o_rel, 32'h10);
        wr(o_pre, 32'h5);
        wr(o_rel, 32'h20);
        rd(o_sts);
        chk(rv, 32'h3);
        settle;
        rd(o_pre);
        chk(rv, 32'h3);
        rd(o_rel);
        chk(rv, 32'h10);
        wr(o_key, 32'h1234);
        wr(o_pre, 32'h1);
        rd(o_pre);
        chk(rv, 32'h3);
        wr(o_key, 32'h5555);
        wr(o_key, 32'haaaa);
        wr(o_rel, 32'hab);
        rd(o_rel);
        chk(rv, 32'h10);
        wr(o_key, 32'h5555);
        wr(o_rel, 32'hfff);
        settle;
        wr(o_key, 32'haaaa);
        $display("test protect done");
    end
    endtask

    task t_divide;
    begin
        wr(o_key, 32'hcccc);
        repeat (3) @(posedge mclk);
        chk(wdg_running, 32'h1);
        for (k = 7; k >= 0; k = k - 1)
        begin
            wr(o_key, 32'h5555);
            wr(o_pre, k);
            settle;
            measure;
            chk(n, (k > 5) ? 4096 : 64 << k);
        end
        $display("test divide done");
    end
    endtask

    task t_freeze;
    begin
        wr(o_key, 32'h4567);
        @(negedge mclk);
        c = wdg_count;
        repeat (300) @(posedge mclk);
        chk(wdg_count, c);
        wr(o_key, 32'h89ab);
        repeat (300) @(posedge mclk);
        chk(wdg_count < c, 32'h1);
        $display("test freeze done");
    end
    endtask

    task t_expire;
    begin
        wr(o_key, 32'h5555);
        wr(o_rel, 32'h3);
        settle;
        wr(o_key, 32'haaaa);
        @(negedge mclk);
        chk(wdg_count, 32'h3);
        n = 0;
        while (wdg_reset_req !== 1'b1 && n < 1000)
        begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(wdg_reset_req, 32'h1);
        chk(wdg_count, 32'h0);
        $display("test expire done");
    end
    endtask

    // second reset with the hardware start strap set
    task t_hwstart;
    begin
        @(posedge mclk);
        reset_n <= 1'b0;
        hw_start_opt <= 1'b1;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(wdg_running, 32'h1);
        chk(wdg_reset_req, 32'h0);
        $display("test hwstart done");
    end
    endtask

    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_protect;
        t_divide;
        t_freeze;
        t_expire;
        t_hwstart;
        report_and_stop;
    end

    // hang guard, about three and a half times the expected run
    initial
    begin
        repeat (90000) @(posedge mclk);
        failures = failures + 1;
        report_and_stop;
    end
endmodule
